// ==== bsr_defs.vh ====
// Constants for the boundary-scan register and its test controller
`ifndef BSR_DEFS_VH
`define BSR_DEFS_VH
`define BSR_CHAIN_LEN 107
`define BSR_CTRL_MASK 107'h0800_2000_1000_8000_0204_0000
`define BSR_IR_LEN 5
`define BSR_OP_EXTEST 5'h00
`define BSR_OP_SAMPLE 5'h01
`define BSR_OP_INTSCAN 5'h02
`define BSR_OP_CLAMP 5'h04
`define BSR_OP_BYPASS 5'h1F
`define BSR_IR_CAPTURE 5'h0D
`define BSR_RESET_CTL 1'h0
`endif

// ==== bsr_tap_fsm.v ====
// Test controller state machine, stepped on detected test clock rising edges
`timescale 1ns/100ps
module bsr_tap_fsm (
   input wire clk,
   input wire rst,
   input wire tckRise,
   input wire tmsLevel,
   output wire inReset,
   output wire capDr,
   output wire shDr,
   output wire updDr,
   output wire capIr,
   output wire shIr,
   output wire updIr
);
   localparam RESET = 16'h0001;
   localparam IDLE = 16'h0002;
   localparam SELDR = 16'h0004;
   localparam CAPDR = 16'h0008;
   localparam SHDR = 16'h0010;
   localparam EX1DR = 16'h0020;
   localparam PSDR = 16'h0040;
   localparam EX2DR = 16'h0080;
   localparam UPDR = 16'h0100;
   localparam SELIR = 16'h0200;
   localparam CAPIR = 16'h0400;
   localparam SHIR = 16'h0800;
   localparam EX1IR = 16'h1000;
   localparam PSIR = 16'h2000;
   localparam EX2IR = 16'h4000;
   localparam UPIR = 16'h8000;

   reg [15:0] state;
   reg [15:0] next_state;

   // Five rising edges with TMS high reach RESET from any state
   always @*
   begin
      case (state)
         RESET: next_state = tmsLevel ? RESET : IDLE;
         IDLE: next_state = tmsLevel ? SELDR : IDLE;
         SELDR: next_state = tmsLevel ? SELIR : CAPDR;
         CAPDR: next_state = tmsLevel ? EX1DR : SHDR;
         SHDR: next_state = tmsLevel ? EX1DR : SHDR;
         EX1DR: next_state = tmsLevel ? UPDR : PSDR;
         PSDR: next_state = tmsLevel ? EX2DR : PSDR;
         EX2DR: next_state = tmsLevel ? UPDR : SHDR;
         UPDR: next_state = tmsLevel ? SELDR : IDLE;
         SELIR: next_state = tmsLevel ? RESET : CAPIR;
         CAPIR: next_state = tmsLevel ? EX1IR : SHIR;
         SHIR: next_state = tmsLevel ? EX1IR : SHIR;
         EX1IR: next_state = tmsLevel ? UPIR : PSIR;
         PSIR: next_state = tmsLevel ? EX2IR : PSIR;
         EX2IR: next_state = tmsLevel ? UPIR : SHIR;
         UPIR: next_state = tmsLevel ? SELDR : IDLE;
         default: next_state = RESET;
      endcase
   end

   always @(posedge clk)
   begin
      if (rst)
         state <= RESET;
      else if (tckRise)
         state <= next_state;
   end

   assign inReset = state[0];
   assign capDr = state[3];
   assign shDr = state[4];
   assign updDr = state[8];
   assign capIr = state[10];
   assign shIr = state[11];
   assign updIr = state[15];
endmodule

// ==== bsr_scan_cell.v ====
// One boundary-scan cell: capture/shift master stage and update slave stage
`timescale 1ns/100ps
`include "bsr_defs.vh"
module bsr_scan_cell (
   input wire clk,
   input wire rst,
   input wire capEn,
   input wire shiftEn,
   input wire updEn,
   input wire parIn,
   input wire serIn,
   output reg capQ,
   output reg updQ
);
   always @(posedge clk)
   begin
      if (rst)
      begin
         capQ <= 1'h0;
         updQ <= `BSR_RESET_CTL;
      end
      else
      begin
         if (capEn)
            capQ <= parIn;
         else if (shiftEn)
            capQ <= serIn;
         if (updEn)
            updQ <= capQ;
      end
   end
endmodule

// ==== bsr_tap_top.v ====
// Boundary-scan chain with its test access port, run from the system clock
//
// Contract
// - One cell per pin plus control cells
// - Control cell one enables its pins' outputs
// - No cells for supply or test pins
// - Cells are dedicated master/slave test logic
// - Sample/extest capture pins on TCK rise
// - Shift TDI into chain per TCK rise
// - Slave stages update on TCK fall
// - TDO changes on TCK falling edge
// - Controller steps on TCK rise by TMS
// - Low test reset initialises the controller
// - Five TMS-high clocks reset the controller
// - Fixed chain order, cells 0 to 106
// - TDI feeds MSB, LSB drives TDO
// - Five-bit master/slave instruction register
// - All-zero opcode: chain selected, pins driven
// - All-ones opcode selects one-bit bypass
`timescale 1ns/100ps
`include "bsr_defs.vh"
module bsr_tap_top #(
   parameter LEN = `BSR_CHAIN_LEN,
   parameter [LEN-1:0] CTRL_MASK = `BSR_CTRL_MASK
) (
   input wire clk,
   input wire rst,
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire trstN,
   output reg tdo,
   output reg tdoOe,
   input wire [LEN-1:0] pinIn,
   input wire [LEN-1:0] sysOut,
   input wire [LEN-1:0] sysOe,
   output reg [LEN-1:0] pinOut,
   output reg [LEN-1:0] pinOe,
   output reg [LEN-1:0] coreIn
);
   // Control cell governing a pin: next control above, else last below
   function integer bsr_ctl_of;
      input integer idx;
      integer k;
      begin
         bsr_ctl_of = -1;
         for (k = LEN - 1; k >= idx; k = k - 1)
            if (CTRL_MASK[k])
               bsr_ctl_of = k;
         if (bsr_ctl_of < 0)
            for (k = 0; k < idx; k = k + 1)
               if (CTRL_MASK[k])
                  bsr_ctl_of = k;
         if (bsr_ctl_of < 0)
            bsr_ctl_of = idx;
      end
   endfunction

   // Test pins come from another domain: two flops before any logic
   reg [3:0] syncA;
   reg [3:0] syncB;
   reg tckPrev;
   reg [LEN-1:0] pinSyncA;
   reg [LEN-1:0] pinSyncB;

   always @(posedge clk)
   begin
      if (rst)
      begin
         syncA <= 4'h8;
         syncB <= 4'h8;
         tckPrev <= 1'h0;
      end
      else
      begin
         syncA <= {trstN, tdi, tms, tck};
         syncB <= syncA;
         tckPrev <= syncB[0];
      end
   end

   // Pin levels resync as a bus; a skewed bit settles one clock later
   always @(posedge clk)
   begin
      if (rst)
      begin
         pinSyncA <= {LEN{1'b0}};
         pinSyncB <= {LEN{1'b0}};
      end
      else
      begin
         pinSyncA <= pinIn;
         pinSyncB <= pinSyncA;
      end
   end

   wire tckS;
   wire tmsS;
   wire tdiS;
   wire trstS;
   wire tckRise;
   wire tckFall;
   wire tapRst;

   assign tckS = syncB[0];
   assign tmsS = syncB[1];
   assign tdiS = syncB[2];
   assign trstS = ~syncB[3];
   // Edge detection costs up to three clocks of latency; TCK must be slow
   assign tckRise = tckS & ~tckPrev;
   assign tckFall = ~tckS & tckPrev;
   assign tapRst = rst | trstS;

   // Controller state strobes, one per state the test logic uses
   wire inReset;
   wire capDr;
   wire shDr;
   wire updDr;
   wire capIr;
   wire shIr;
   wire updIr;

   bsr_tap_fsm uFsm (
      .clk(clk),
      .rst(tapRst),
      .tckRise(tckRise),
      .tmsLevel(tmsS),
      .inReset(inReset),
      .capDr(capDr),
      .shDr(shDr),
      .updDr(updDr),
      .capIr(capIr),
      .shIr(shIr),
      .updIr(updIr)
   );

   // Instruction register: shift master, latched slave
   reg [`BSR_IR_LEN-1:0] irShift;
   reg [`BSR_IR_LEN-1:0] irActive;

   // Master half captures the fixed pattern, then shifts toward TDO
   always @(posedge clk)
   begin
      if (tapRst)
         irShift <= `BSR_IR_CAPTURE;
      else if (tckRise && capIr)
         irShift <= `BSR_IR_CAPTURE;
      else if (tckRise && shIr)
         irShift <= {tdiS, irShift[`BSR_IR_LEN-1:1]};
   end

   // Slave half: a half-shifted opcode never reaches the decode
   always @(posedge clk)
   begin
      if (tapRst || inReset)
         irActive <= `BSR_OP_BYPASS;
      else if (tckFall && updIr)
         irActive <= irShift;
   end

   // Unknown opcodes fall back to bypass, the safe choice
   wire opExtest;
   wire opSample;
   wire opIntscan;
   wire opClamp;
   wire bsrSel;
   wire pinOvr;

   assign opExtest = (irActive == `BSR_OP_EXTEST);
   assign opSample = (irActive == `BSR_OP_SAMPLE);
   assign opIntscan = (irActive == `BSR_OP_INTSCAN);
   assign opClamp = (irActive == `BSR_OP_CLAMP);
   assign bsrSel = opExtest | opSample | opIntscan;
   // Clamp freezes the pins yet keeps the short bypass path for shifting
   assign pinOvr = opExtest | opClamp;

   reg bypassBit;
   reg next_bypass;

   always @*
   begin
      next_bypass = bypassBit;
      if (tckRise && capDr && !bsrSel)
         next_bypass = 1'h0;
      else if (tckRise && shDr && !bsrSel)
         next_bypass = tdiS;
   end

   always @(posedge clk)
   begin
      if (tapRst)
         bypassBit <= 1'h0;
      else
         bypassBit <= next_bypass;
   end

   // Chain strobes
   wire cellCap;
   wire cellShift;
   wire cellUpd;

   assign cellCap = tckRise & capDr & bsrSel;
   assign cellShift = tckRise & shDr & bsrSel;
   assign cellUpd = tckFall & updDr & bsrSel;
   wire [LEN-1:0] capQ;
   wire [LEN-1:0] updQ;

   // Chain holds the functional pins and the control cells, cell 0 nearest TDO
   genvar i;
   generate
      for (i = 0; i < LEN; i = i + 1)
      begin : gCell
         localparam integer CI = bsr_ctl_of(i);
         wire parIn = CTRL_MASK[i] ? sysOe[i] : pinSyncB[i];
         wire serIn;
         if (i == LEN - 1)
         begin : gTop
            assign serIn = tdiS;
         end
         else
         begin : gMid
            assign serIn = capQ[i+1];
         end

         // Slaves keep their data through a controller reset; test reset clears them
         bsr_scan_cell uCell (
            .clk(clk),
            .rst(tapRst),
            .capEn(cellCap),
            .shiftEn(cellShift),
            .updEn(cellUpd),
            .parIn(parIn),
            .serIn(serIn),
            .capQ(capQ[i]),
            .updQ(updQ[i])
         );

         // Registered pin drive; control cells drive no pin
         always @(posedge clk)
         begin
            if (rst || CTRL_MASK[i])
               pinOut[i] <= 1'h0;
            else
               pinOut[i] <= pinOvr ? updQ[i] : sysOut[i];
         end

         always @(posedge clk)
         begin
            if (rst || CTRL_MASK[i])
               pinOe[i] <= 1'h0;
            else
               pinOe[i] <= pinOvr ? updQ[CI] : sysOe[CI];
         end

         // Core sees the pins unless internal scan takes over
         always @(posedge clk)
         begin
            if (rst || CTRL_MASK[i])
               coreIn[i] <= 1'h0;
            else
               coreIn[i] <= opIntscan ? updQ[i] : pinSyncB[i];
         end
      end
   endgenerate

   // Serial output leaves on the falling edge, held otherwise
   reg next_tdo;

   always @*
   begin
      next_tdo = tdo;
      if (shIr)
         next_tdo = irShift[0];
      else if (shDr && bsrSel)
         next_tdo = capQ[0];
      else if (shDr)
         next_tdo = bypassBit;
   end

   always @(posedge clk)
   begin
      if (tapRst)
         tdo <= 1'h0;
      else if (tckFall)
         tdo <= next_tdo;
   end

   // Driver enabled only while a shift state owns the output
   always @(posedge clk)
   begin
      if (tapRst)
         tdoOe <= 1'h0;
      else if (tckFall)
         tdoOe <= shIr | shDr;
   end
endmodule

// ==== bsr_tap_asserts.sv ====
// Checker on the test port and boundary pins, bound into the top module
`timescale 1ns/100ps
module bsr_tap_checker #(
   parameter LEN = 107,
   parameter [LEN-1:0] CTRL_MASK = 0
) (
   input wire clk,
   input wire rst,
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire trstN,
   input wire tdo,
   input wire tdoOe,
   input wire [LEN-1:0] pinIn,
   input wire [LEN-1:0] sysOut,
   input wire [LEN-1:0] sysOe,
   input wire [LEN-1:0] pinOut,
   input wire [LEN-1:0] pinOe,
   input wire [LEN-1:0] coreIn
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Fall is seen 3 to 4 clk late
   tdo_fall_edge_a:
      assert property ($changed(tdo) && (tdoOe || $past(tdoOe)) |-> !$past(tck, 2)
         && !$past(tck, 3)) else $error("tdo moved off a clock fall");
   oe_fall_edge_a:
      assert property ($changed(tdoOe) |-> !$past(tck, 2) && !$past(tck, 3))
         else $error("tdoOe moved off a clock fall");
   oe_by_tms_a:
      assert property ($changed(tdoOe) |-> $past(tms, 6) == !tdoOe)
         else $error("shift state entered against tms");
   ctrl_silent_a:
      assert property (((pinOut | pinOe | coreIn) & CTRL_MASK) == 0)
         else $error("control cell reached a pin");
   reset_clear_a:
      assert property ($fell(rst) |-> !tdo && !tdoOe && pinOut == 0 && coreIn == 0)
         else $error("outputs not cleared by reset");
   trst_quiet_a:
      assert property (!trstN [*4] |-> !tdo && !tdoOe) else $error("test reset ignored");
   bypass_pins_a:
      assert property ((!trstN && sysOut == $past(sysOut, 2)) [*6]
         |-> pinOut == (sysOut & ~CTRL_MASK)) else $error("pins not left to the core");
   bypass_core_a:
      assert property ((!trstN && $stable(pinIn)) [*6]
         |-> coreIn == (pinIn & ~CTRL_MASK)) else $error("core inputs overridden");
   cover property ($rose(tdoOe));
   cover property ($fell(rst));
   cover property (!trstN [*6]);
endmodule
bind bsr_tap_top bsr_tap_checker #(.LEN(LEN), .CTRL_MASK(CTRL_MASK)) chk (.clk(clk),
   .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe),
   .pinIn(pinIn), .sysOut(sysOut), .sysOe(sysOe), .pinOut(pinOut), .pinOe(pinOe),
   .coreIn(coreIn));

// ==== bsr_tap_master.sv ====
// Test master model that sequences the test port
`timescale 1ns/100ps
module bsr_tap_master (
   input wire clk,
   input wire tdo,
   output reg tck,
   output reg tms,
   output reg tdi,
   output reg trstN
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trstN = 1'b0;
   end
   task setTrst(input v);
   begin
      trstN <= v;
   end
   endtask
   // Half periods of 4 clk; tdo taken late, as it only moves after a fall
   task bitx(input t, input d, output o);
   begin
      tms <= t;
      tdi <= d;
      repeat (4) @(posedge clk);
      tck <= 1'b1;
      repeat (4) @(posedge clk);
      o = tdo;
      tck <= 1'b0;
   end
   endtask
   task reset5;
      reg o;
   begin
      repeat (5) bitx(1'b1, 1'b0, o);
      bitx(1'b0, 1'b0, o);
   end
   endtask
   // From idle through capture, n shifts, update, back to idle
   task scan(input ir, input [114:0] din, input integer n, output [114:0] dout);
      integer i;
      reg o;
   begin
      dout = 0;
      bitx(1'b1, 1'b0, o);
      if (ir)
         bitx(1'b1, 1'b0, o);
      bitx(1'b0, 1'b0, o);
      bitx(1'b0, 1'b0, o);
      for (i = 0; i < n; i = i + 1)
      begin
         bitx(i == n - 1, din[i], o);
         dout[i] = o;
      end
      bitx(1'b1, 1'b0, o);
      bitx(1'b0, 1'b0, o);
   end
   endtask
endmodule

// ==== bsr_tap_top_tb.sv ====
// Self-checking bench for the boundary-scan chain and its test port
`timescale 1ns/100ps
`include "bsr_defs.vh"
module bsr_tap_top_tb;
   localparam L = `BSR_CHAIN_LEN;
   localparam [L-1:0] M = `BSR_CTRL_MASK;
   localparam [107:0] PA = {27{4'h9}};
   localparam [107:0] PB = {27{4'h3}};
   localparam [107:0] PC = {27{4'h6}};
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [L-1:0] pinIn = PA[L-1:0];
   reg [L-1:0] sysOut = PB[L-1:0];
   reg [L-1:0] sysOe = PC[L-1:0];
   reg [L-1:0] sl = 0;
   reg [L-1:0] cap;
   reg [114:0] din;
   reg [114:0] dout;
   reg [7:0] row [0:5];
   reg o;
   integer k;
   integer failCount = 0;
   integer comparisons = 0;
   wire tck, tms, tdi, trstN, tdo, tdoOe;
   wire [L-1:0] pinOut, pinOe, coreIn;
   bsr_tap_top DUT (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
      .tdo(tdo), .tdoOe(tdoOe), .pinIn(pinIn), .sysOut(sysOut), .sysOe(sysOe),
      .pinOut(pinOut), .pinOe(pinOe), .coreIn(coreIn));
   bsr_tap_master master (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
      .trstN(trstN));
   always #10 clk = ~clk;
   task chk(input [114:0] seen, input [114:0] exp);
   begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         failCount = failCount + 1;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   end
   endtask
   // Each data cell follows the nearest control cell at or above it; cells above 91 follow cell 91
   function [L-1:0] grp(input [L-1:0] v);
      integer i;
      reg c;
   begin
      c = v[91];
      for (i = L - 1; i >= 0; i = i - 1)
      begin
         if (M[i])
            c = v[i];
         grp[i] = !M[i] && c;
      end
   end
   endfunction
   task pins(input drv, input cor);
   begin
      chk(pinOut, (drv ? sl : sysOut) & ~M);
      chk(pinOe, grp(drv ? sl : sysOe));
      chk(coreIn, (cor ? sl : pinIn) & ~M);
   end
   endtask
   task conclude;
   begin
      $display("comparisons %0d failCount %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   initial
   begin
      #1000000;
      failCount = failCount + 1;
      conclude;
   end
   initial
   begin
      row[0] = {3'h4, `BSR_OP_SAMPLE};
      row[1] = {3'h6, `BSR_OP_EXTEST};
      row[2] = {3'h2, `BSR_OP_CLAMP};
      row[3] = {3'h5, `BSR_OP_INTSCAN};
      row[4] = {3'h0, `BSR_OP_BYPASS};
      row[5] = {3'h0, 5'h15};
      cap = (pinIn & ~M) | (sysOe & M);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      master.setTrst(1'b1);
      repeat (4) @(posedge clk);
      master.reset5;
      for (k = 0; k < 6; k = k + 1)
      begin
         master.scan(1'b1, {110'h0, row[k][4:0]}, 5, dout);
         chk(dout[4:0], `BSR_IR_CAPTURE);
         din = {PB[L-1:0] ^ {L{k[0]}}, 8'hA5};
         master.scan(1'b0, din, L + 8, dout);
         chk(dout, row[k][7] ? {din[7:0], cap} : {din[113:0], 1'b0});
         if (row[k][7])
            sl = din[114:8];
         pins(row[k][6], row[k][5]);
         $display("row %0d done", k);
      end
      // One shift then three more highs leaves extest standing
      master.scan(1'b1, 115'h0, 5, dout);
      master.bitx(1'b1, 1'b0, o);
      master.bitx(1'b0, 1'b0, o);
      master.bitx(1'b0, 1'b0, o);
      repeat (4) master.bitx(1'b1, 1'b0, o);
      sl = {1'b0, cap[L-1:1]};
      pins(1'b1, 1'b0);
      master.bitx(1'b1, 1'b0, o);
      master.bitx(1'b0, 1'b0, o);
      pins(1'b0, 1'b0);
      $display("five high test done");
      master.scan(1'b1, 115'h0, 5, dout);
      // Controller reset leaves the slave stages as they were
      pins(1'b1, 1'b0);
      master.setTrst(1'b0);
      repeat (6) @(posedge clk);
      pins(1'b0, 1'b0);
      chk(tdo, 1'b0);
      master.setTrst(1'b1);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      sysOut <= ~sysOut;
      repeat (6) @(posedge clk);
      pins(1'b0, 1'b0);
      $display("reset tests done");
      conclude;
   end
endmodule
